// [rtl/cfg_blink_pkg.sv]
// Package: register offsets, field positions and reset values of the configuration bank
package cfg_blink_pkg;
  localparam logic [7:0] ADDR_INPUT_PORTS   = 8'h00;
  localparam logic [7:0] ADDR_PHASE0        = 8'h02;
  localparam logic [7:0] ADDR_PHASE1        = 8'h0A;
  localparam logic [7:0] ADDR_MASTER_INTENS = 8'h0E;
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h0F;
  localparam logic [7:0] ADDR_INTENS_FIRST  = 8'h10;
  localparam logic [7:0] ADDR_INTENS_LAST   = 8'h13;

  localparam int BIT_BLINK_EN    = 0;
  localparam int BIT_BLINK_FLIP  = 1;
  localparam int BIT_GLOBAL_INT  = 2;
  localparam int BIT_IRQ_EN      = 3;
  localparam int BIT_GPO_PHASE0  = 4;
  localparam int BIT_GPO_PHASE1  = 5;
  localparam int BIT_BLINK_STAT  = 6;
  localparam int BIT_IRQ_STAT    = 7;

  localparam logic [5:0] CONFIG_RESET  = 6'h0C;
  localparam logic [7:0] PHASE_RESET   = 8'hFF;
  localparam logic [7:0] MASTER_RESET  = 8'h0F;
  localparam logic [7:0] INTENS_RESET  = 8'hFF;
  localparam logic [7:0] INPUTS_RESET  = 8'hFF;
  localparam logic [2:0] WARMUP_RESET  = 3'h7;
endpackage

// [rtl/input_change_detect.sv]
// Input change detection: sample of the port inputs and a compare against it
`timescale 1ns/100ps
module input_change_detect
  import cfg_blink_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Synchronised port levels and direction
  input  wire logic [7:0] port_level,
  input  wire logic [7:0] port_is_input,
  // Resample request
  input  wire logic       resample,
  // Result
  output logic            change_q
);
  logic [7:0] sample_q;
  logic [2:0] first_q;

  // Sample retaken until the synchronisers have flushed their reset value,
  // so that settled inputs raise nothing after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sample_q <= INPUTS_RESET;
      first_q  <= WARMUP_RESET;
    end else begin
      first_q <= {first_q[1:0], 1'b0};
      if ((|first_q) || resample) begin
        sample_q <= port_level;
      end
    end
  end

  // Level compare: clears by itself when the input returns
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      change_q <= 1'b0;
    end else begin
      change_q <= !(|first_q) && !resample
                  && (|((port_level ^ sample_q) & port_is_input));
    end
  end
endmodule

// [rtl/device_config_bank.sv]
// Configuration register bank: blink, intensity select and combined irq/output pin
// How it works
// - Config bit 0 written 1 enables blink mode, written 0 disables it.
// - With blink on, config bit 1 is the software flip for phase choice.
// - Blink phase is flip bit XOR blink pin; phase 0 first pattern, 1 second.
// - Blink off: flip ignored, ports driven only from phase 0 pattern.
// - Bit 2 clear: per-port intensity registers; pin uses master low nibble.
// - Bit 2 set: master low nibble intensity drives every output port.
// - Bit 3 set: combined pin shows detected input data changes.
// - Bit 3 clear: combined pin is a general output from the two level bits.
// - Blink off: pin low when bit 4 is 0, released when 1.
// - Blink on, phase 0: pin low when bit 4 is 0, released when 1.
// - Blink on, phase 1: pin low when bit 5 is 0, released when 1.
// - Bit 6 reads the present blink pin level and is read-only.
// - Bit 7 reads change status; with irq on pin low when set.
// - Change flag rises on input mismatch; clears on return, inputs read or config write.
`timescale 1ns/100ps
module device_config_bank
  import cfg_blink_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register access from the serial interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_q,
  // Pins
  input  wire logic       blink_pin,
  input  wire logic [7:0] port_pins,
  input  wire logic [7:0] port_is_input,
  output logic            irq_or_gpo_pin_o,
  output logic            irq_or_gpo_pin_oe_n,
  // Towards port drivers and PWM
  output logic [7:0]      port_pattern_q,
  output logic            use_global_intensity_q,
  output logic [3:0]      pin_intensity_q,
  output logic            blink_phase_q
);
  logic [5:0] cfg_q;
  logic [7:0] phase0_q;
  logic [7:0] phase1_q;
  logic [7:0] master_q;
  logic [7:0] intens_q [4];
  logic [1:0] blink_sync_q;
  logic [7:0] port_meta_q;
  logic [7:0] port_sync_q;
  logic       change_q;
  logic       resample;
  logic       phase;
  logic       gpo_release;
  logic [7:0] rdata_d;
  logic       wr_cfg;
  logic       wr_phase0;
  logic       wr_phase1;
  logic       wr_master;
  logic       rd_inputs;

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blink_sync_q <= 2'b00;
    end else begin
      blink_sync_q <= {blink_sync_q[0], blink_pin};
    end
  end

  // Port levels reset high, the idle level of released open-drain ports
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_meta_q <= INPUTS_RESET;
      port_sync_q <= INPUTS_RESET;
    end else begin
      port_meta_q <= port_pins;
      port_sync_q <= port_meta_q;
    end
  end

  // Address decode shared by config, phase and master storage and resample paths; intensity writes and read data decode reg_addr themselves
  assign wr_cfg    = reg_wr && (reg_addr == ADDR_DEVICE_CONFIG);
  assign wr_phase0 = reg_wr && (reg_addr == ADDR_PHASE0);
  assign wr_phase1 = reg_wr && (reg_addr == ADDR_PHASE1);
  assign wr_master = reg_wr && (reg_addr == ADDR_MASTER_INTENS);
  assign rd_inputs = reg_rd && (reg_addr == ADDR_INPUT_PORTS);

  // Configuration: only bits 5..0 are stored, status bits are never written
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q <= CONFIG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= reg_wdata[5:0];
    end
  end

  // Pattern and intensity storage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase0_q <= PHASE_RESET;
    end else if (wr_phase0) begin
      phase0_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase1_q <= PHASE_RESET;
    end else if (wr_phase1) begin
      phase1_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      master_q <= MASTER_RESET;
    end else if (wr_master) begin
      master_q <= reg_wdata;
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_intens
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          intens_q[i] <= INTENS_RESET;
        end else if (reg_wr && reg_addr == ADDR_INTENS_FIRST + 8'(i)) begin
          intens_q[i] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Inputs read or config write refresh the compare sample; that sample is
  // the latch taken by an inputs read, so no second copy is kept
  assign resample = rd_inputs || wr_cfg;

  input_change_detect u_detect (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .port_level    (port_sync_q),
    .port_is_input (port_is_input),
    .resample      (resample),
    .change_q      (change_q)
  );

  // Phase forced to 0 when blink is off so the flip bit has no effect
  assign phase = cfg_q[BIT_BLINK_EN]
                 && (cfg_q[BIT_BLINK_FLIP] ^ blink_sync_q[1]);

  assign gpo_release = phase ? cfg_q[BIT_GPO_PHASE1]
                             : cfg_q[BIT_GPO_PHASE0];

  // Outputs toward ports and PWM, one register per concern
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blink_phase_q <= 1'b0;
    end else begin
      blink_phase_q <= phase;
    end
  end

  // Pattern changes on the same edge as the pin, so ports and pin blink together
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_pattern_q <= PHASE_RESET;
    end else begin
      port_pattern_q <= phase ? phase1_q : phase0_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      use_global_intensity_q <= CONFIG_RESET[BIT_GLOBAL_INT];
    end else begin
      use_global_intensity_q <= cfg_q[BIT_GLOBAL_INT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_intensity_q <= MASTER_RESET[3:0];
    end else begin
      pin_intensity_q <= master_q[3:0];
    end
  end

  // Open-drain pin: drive low or release; oe_n low means driving
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_or_gpo_pin_o    <= 1'b0;
      irq_or_gpo_pin_oe_n <= 1'b1;
    end else if (cfg_q[BIT_IRQ_EN]) begin
      irq_or_gpo_pin_o    <= 1'b0;
      irq_or_gpo_pin_oe_n <= !change_q;
    end else begin
      irq_or_gpo_pin_o    <= 1'b0;
      irq_or_gpo_pin_oe_n <= gpo_release;
    end
  end

  // Read data
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == ADDR_INPUT_PORTS) begin
      rdata_d = port_sync_q;
    end else if (reg_addr == ADDR_PHASE0) begin
      rdata_d = phase0_q;
    end else if (reg_addr == ADDR_PHASE1) begin
      rdata_d = phase1_q;
    end else if (reg_addr == ADDR_MASTER_INTENS) begin
      rdata_d = master_q;
    end else if (reg_addr == ADDR_DEVICE_CONFIG) begin
      rdata_d = {change_q, blink_sync_q[1], cfg_q};
    end else if (reg_addr >= ADDR_INTENS_FIRST && reg_addr <= ADDR_INTENS_LAST) begin
      rdata_d = intens_q[reg_addr[1:0]];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end
endmodule

// [tb/device_config_bank_assertions.sv]
// Checker of the configuration bank ports
`timescale 1ns/100ps
module device_config_bank_assertions
  import cfg_blink_pkg::*;
(
  // Clock, reset and register port
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Pins and status
  input wire logic       blink_pin,
  input wire logic       irq_or_gpo_pin_o,
  input wire logic       irq_or_gpo_pin_oe_n,
  input wire logic       use_global_intensity_q,
  input wire logic       blink_phase_q
);
  logic [5:0] cfg_q;
  logic       rd_cfg;
  // Shadow of the writable bits, so outputs can be judged against writes
  always_ff @(posedge clk_sys)
    if (!rst_n) cfg_q <= CONFIG_RESET;
    else if (reg_wr && reg_addr == ADDR_DEVICE_CONFIG) cfg_q <= reg_wdata[5:0];
  assign rd_cfg = reg_rd && !reg_wr && reg_addr == ADDR_DEVICE_CONFIG;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rdcfg; rd_cfg |=> reg_rdata_q[5:0] == cfg_q; endproperty
  a_rdcfg: assert property (p_rdcfg) else $error("cfg read");
  property p_ph; (cfg_q[0] && $stable(cfg_q) && $stable(blink_pin))[*5]
    |-> blink_phase_q == (cfg_q[1] ^ blink_pin); endproperty
  a_ph: assert property (p_ph) else $error("phase");
  property p_off; (!cfg_q[0])[*3] |-> !blink_phase_q; endproperty
  a_off: assert property (p_off) else $error("phase off");
  property p_glb; ($stable(cfg_q))[*3] |-> use_global_intensity_q == cfg_q[2]; endproperty
  a_glb: assert property (p_glb) else $error("global");
  property p_gpo; (!cfg_q[3] && $stable(cfg_q) && $stable(blink_phase_q))[*3]
    |-> irq_or_gpo_pin_oe_n == (blink_phase_q ? cfg_q[5] : cfg_q[4]); endproperty
  a_gpo: assert property (p_gpo) else $error("gpo");
  property p_irq; rd_cfg && cfg_q[3] && $stable(cfg_q)
    |=> reg_rdata_q[7] == !irq_or_gpo_pin_oe_n; endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_bst; ($stable(blink_pin))[*3] ##0 rd_cfg
    |=> reg_rdata_q[6] == $past(blink_pin); endproperty
  a_bst: assert property (p_bst) else $error("blink status");
  property p_od; irq_or_gpo_pin_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("drive");
  property p_clr; reg_rd && !reg_wr && reg_addr == ADDR_INPUT_PORTS && cfg_q[3]
    |-> ##2 irq_or_gpo_pin_oe_n; endproperty
  a_clr: assert property (p_clr) else $error("irq clear");
  c_blk: cover property (rd_cfg && cfg_q[0]);
  c_irq: cover property (!irq_or_gpo_pin_oe_n && cfg_q[3]);
  c_ph: cover property (blink_phase_q);
endmodule
bind device_config_bank device_config_bank_assertions chk (.*);

// [tb/host_model.sv]
// Host side of the strobed register port
`timescale 1ns/100ps
module host_model (
  input  wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
  // Released data is inverted so a stale value never reads as valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(negedge clk_sys);
    {reg_wdata, reg_wr, reg_rd} = {~d, 2'b00};
  endtask
endmodule

// [tb/port_expander_config_blink_ctrl_bench.sv]
// Self-checking bench of the configuration bank
`timescale 1ns/100ps
module port_expander_config_blink_ctrl_bench;
  import cfg_blink_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, blink_pin, rd_d, irq_or_gpo_pin_o;
  logic irq_or_gpo_pin_oe_n, use_global_intensity_q, blink_phase_q, ph;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, port_pins, port_is_input;
  logic [7:0] port_pattern_q, p0, p1, m, r;
  logic [3:0] pin_intensity_q;
  logic [7:0] exp_q[$];
  logic [31:0] s;
  int miscompares, compares;
  device_config_bank dut (.*);
  host_model host (.*);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] e);
    compares++;
    if (seen !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic pin(input logic [7:0] e);
    chk("oe_n", {7'h00, irq_or_gpo_pin_oe_n}, e);
    chk("pin_o", {7'h00, irq_or_gpo_pin_o}, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) if (rd_d === 1'b1) chk("rdata", reg_rdata_q, exp_q.pop_front());
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    {rst_n, blink_pin, port_pins, port_is_input, s} = {2'b00, 16'h5AFF, 32'h2770};
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(ADDR_DEVICE_CONFIG, 8'h0C);
    rd(8'h05, 8'h00);
    pin(8'h01);
    s = xs(s);
    {m, p1, p0} = s[23:0];
    host.xfer(1'b1, ADDR_PHASE0, p0);
    host.xfer(1'b1, ADDR_PHASE1, p1);
    host.xfer(1'b1, ADDR_MASTER_INTENS, m);
    repeat (16) begin
      s = xs(s);
      {blink_pin, r} = s[8:0];
      host.xfer(1'b1, ADDR_DEVICE_CONFIG, r);
      settle;
      ph = r[0] & (r[1] ^ blink_pin);
      rd(ADDR_DEVICE_CONFIG, {1'b0, blink_pin, r[5:0]});
      chk("phase", {7'h00, blink_phase_q}, {7'h00, ph});
      chk("pattern", port_pattern_q, ph ? p1 : p0);
      chk("global", {7'h00, use_global_intensity_q}, {7'h00, r[2]});
      pin({7'h00, r[3] | (ph ? r[5] : r[4])});
    end
    chk("intensity", {4'h0, pin_intensity_q}, {4'h0, m[3:0]});
    host.xfer(1'b1, ADDR_DEVICE_CONFIG, 8'h08);
    port_pins = 8'h5B;
    settle;
    pin(8'h00);
    rd(ADDR_DEVICE_CONFIG, {1'b1, blink_pin, 6'h08});
    port_pins = 8'h5A;
    settle;
    pin(8'h01);
    port_pins = 8'h7A;
    settle;
    rd(ADDR_INPUT_PORTS, 8'h7A);
    settle;
    pin(8'h01);
    rd(ADDR_DEVICE_CONFIG, {1'b0, blink_pin, 6'h08});
    port_is_input = 8'hDF;
    port_pins = 8'h5A;
    settle;
    pin(8'h01);
    port_is_input = 8'hFF;
    settle;
    pin(8'h00);
    rd(ADDR_INPUT_PORTS, 8'h5A);
    settle;
    pin(8'h01);
    report_and_stop;
  end
endmodule
